/* File: src/tap_pkg.sv */
// Package for the boundary-scan test access port: states, opcodes,
// register widths and reset values.
// Assumes a single test port per device and a 4-bit instruction register.
package tap_pkg;

  // Controller states, Gray coded around the usual walk
  typedef enum logic [3:0] {
    ST_RESET    = 4'h0,
    ST_IDLE     = 4'h1,
    ST_SEL_DR   = 4'h3,
    ST_CAP_DR   = 4'h2,
    ST_SHIFT_DR = 4'h6,
    ST_EX1_DR   = 4'h7,
    ST_PAUSE_DR = 4'h5,
    ST_EX2_DR   = 4'h4,
    ST_UPD_DR   = 4'hc,
    ST_SEL_IR   = 4'hd,
    ST_CAP_IR   = 4'hf,
    ST_SHIFT_IR = 4'he,
    ST_EX1_IR   = 4'ha,
    ST_PAUSE_IR = 4'hb,
    ST_EX2_IR   = 4'h9,
    ST_UPD_IR   = 4'h8
  } tap_state_t;

  localparam int IR_W = 4;
  localparam int DR_MAX_W = 32;
  localparam int ID_W = 32;
  localparam int STAT_W = 16;
  localparam int CTRL_W = 16;
  localparam int LEN_W = 6;

  typedef logic [IR_W-1:0] ir_t;

  // Instruction opcodes
  localparam ir_t IR_EXTEST = 4'h0;
  localparam ir_t IR_SAMPLE = 4'h1;
  localparam ir_t IR_IDCODE = 4'h2;
  localparam ir_t IR_BYPASS = 4'hf;

  // Fixed pattern loaded into the instruction shifter on capture
  localparam ir_t IR_CAPTURE = 4'h1;
  localparam ir_t IR_RST = IR_IDCODE;

  // Data register lengths
  localparam logic [LEN_W-1:0] LEN_BYPASS = 6'h01;
  localparam logic [LEN_W-1:0] LEN_ID = 6'h20;
  localparam logic [LEN_W-1:0] LEN_STAT = 6'h10;
  localparam logic [LEN_W-1:0] LEN_CTRL = 6'h10;

  // Identity word; value is arbitrary, bit 0 set as the scan convention asks
  localparam logic [ID_W-1:0] ID_DEFAULT = 32'h0000_1001;

  localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [STAT_W-1:0] STAT_RST = 16'h0000;

endpackage

/* File: src/word_cross.sv */
// Word crossing between two unrelated clocks by a toggle handshake.
// Assumes both resets are synchronous to their own clock, active low.
`timescale 1ns/10ps
module word_cross #(
  parameter int W = 16
) (
  input  wire logic         src_clk_i,
  input  wire logic         src_rstn_i,
  input  wire logic         src_valid_i,
  output logic              src_ready_o,
  input  wire logic [W-1:0] src_data_i,
  input  wire logic         dst_clk_i,
  input  wire logic         dst_rstn_i,
  output logic              dst_valid_o,
  output logic [W-1:0]      dst_data_o
);

  logic req_q;
  logic [W-1:0] hold_q;
  logic [1:0] ack_sync_q;
  logic [1:0] req_sync_q;
  logic seen_q;
  logic valid_q;
  logic [W-1:0] data_q;

  // Source idles once the returned acknowledge matches its request
  assign src_ready_o = (req_q == ack_sync_q[1]);

  // Held word stays still while a request is in flight
  always_ff @(posedge src_clk_i) begin
    if (!src_rstn_i) begin
      req_q <= 1'b0;
      hold_q <= '0;
    end else if (src_valid_i && src_ready_o) begin
      req_q <= ~req_q;
      hold_q <= src_data_i;
    end
  end

  always_ff @(posedge src_clk_i) begin
    if (!src_rstn_i) begin
      ack_sync_q <= 2'h0;
    end else begin
      ack_sync_q <= {ack_sync_q[0], seen_q};
    end
  end

  always_ff @(posedge dst_clk_i) begin
    if (!dst_rstn_i) begin
      req_sync_q <= 2'h0;
    end else begin
      req_sync_q <= {req_sync_q[0], req_q};
    end
  end

  always_ff @(posedge dst_clk_i) begin
    if (!dst_rstn_i) begin
      seen_q <= 1'b0;
      valid_q <= 1'b0;
      data_q <= '0;
    end else begin
      valid_q <= 1'b0;
      if (req_sync_q[1] != seen_q) begin
        seen_q <= req_sync_q[1];
        valid_q <= 1'b1;
        data_q <= hold_q;
      end
    end
  end

  assign dst_valid_o = valid_q;
  assign dst_data_o = data_q;

endmodule

/* File: src/tap_port.sv */
// Boundary-scan test access port with its own test clock domain.
// Assumes pads with pull-ups on mode-select, data-in and test reset, and a
// separate system clock domain that supplies status and takes control words.
`timescale 1ns/10ps

// Overview of operation
// RULE1: The test clock from the outside controller is the only clock of the scan logic, apart from system clocks.
// RULE2: The controller state changes only as the sampled mode-select value dictates.
// RULE3: Instruction and data bits enter from the data-in pin one per test clock while in a shift state.
// RULE4: The serial data output changes on the falling edge of the test clock.
// RULE5: The serial data output is high impedance whenever no shift is in progress.
// RULE6: A low test reset forces the controller to the reset state at once, with no clock edge.
// RULE7: The outside party pulses the test reset low at power-up when scan testing is wanted.
// RULE8: The outside party holds the test reset low during normal functional operation.
// RULE9: The controller walks the standard sixteen states, sampling mode-select and data-in on the rising edge.
// RULE10: Undriven mode-select, data-in and reset read high, so a floating mode-select returns the controller to reset.
module tap_port (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic tck_i,
  input  wire logic trst_n_i,
  input  wire logic tms_i,
  input  wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_n_o,
  input  wire logic [tap_pkg::STAT_W-1:0] sys_status_i,
  output logic [tap_pkg::CTRL_W-1:0] test_ctrl_o,
  output logic test_ctrl_valid_o,
  output logic test_mode_o
);
  import tap_pkg::*;

  tap_state_t state_q;
  tap_state_t state_d;
  ir_t ir_q;
  ir_t ir_sh_q;
  logic [DR_MAX_W-1:0] dr_sh_q;
  logic [DR_MAX_W-1:0] dr_sh_d;
  logic [LEN_W-1:0] dr_len;
  logic [1:0] tck_rst_q;
  logic tck_rstn;
  logic tdo_q;
  logic tdo_en_q;
  logic [CTRL_W-1:0] ctrl_tck_q;
  logic ctrl_pend_q;
  logic ctrl_ready;
  logic [STAT_W-1:0] stat_tck_q;
  logic stat_valid;
  logic [STAT_W-1:0] stat_data;
  logic stat_ready;
  logic extest_q;
  logic [1:0] mode_sync_q;
  logic ctrl_valid;
  logic [CTRL_W-1:0] ctrl_data;
  logic [CTRL_W-1:0] ctrl_q;
  logic ctrl_vld_q;

  // Length of the data register selected by an instruction
  function automatic logic [LEN_W-1:0] len_of(input ir_t ir);
    logic [LEN_W-1:0] len;
    len = LEN_BYPASS;
    if (ir == IR_IDCODE) begin
      len = LEN_ID;
    end else if (ir == IR_SAMPLE) begin
      len = LEN_STAT;
    end else if (ir == IR_EXTEST) begin
      len = LEN_CTRL;
    end
    return len;
  endfunction

  // Next state from the sampled mode-select only [RULE2] [RULE9]
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        state_d = tms_i ? ST_RESET : ST_IDLE;
      end
      ST_IDLE: begin
        state_d = tms_i ? ST_SEL_DR : ST_IDLE;
      end
      ST_SEL_DR: begin
        state_d = tms_i ? ST_SEL_IR : ST_CAP_DR;
      end
      ST_CAP_DR: begin
        state_d = tms_i ? ST_EX1_DR : ST_SHIFT_DR;
      end
      ST_SHIFT_DR: begin
        state_d = tms_i ? ST_EX1_DR : ST_SHIFT_DR;
      end
      ST_EX1_DR: begin
        state_d = tms_i ? ST_UPD_DR : ST_PAUSE_DR;
      end
      ST_PAUSE_DR: begin
        state_d = tms_i ? ST_EX2_DR : ST_PAUSE_DR;
      end
      ST_EX2_DR: begin
        state_d = tms_i ? ST_UPD_DR : ST_SHIFT_DR;
      end
      ST_UPD_DR: begin
        state_d = tms_i ? ST_SEL_DR : ST_IDLE;
      end
      ST_SEL_IR: begin
        // A mode-select left floating by its pull-up walks back to reset [RULE10]
        state_d = tms_i ? ST_RESET : ST_CAP_IR;
      end
      ST_CAP_IR: begin
        state_d = tms_i ? ST_EX1_IR : ST_SHIFT_IR;
      end
      ST_SHIFT_IR: begin
        state_d = tms_i ? ST_EX1_IR : ST_SHIFT_IR;
      end
      ST_EX1_IR: begin
        state_d = tms_i ? ST_UPD_IR : ST_PAUSE_IR;
      end
      ST_PAUSE_IR: begin
        state_d = tms_i ? ST_EX2_IR : ST_PAUSE_IR;
      end
      ST_EX2_IR: begin
        state_d = tms_i ? ST_UPD_IR : ST_SHIFT_IR;
      end
      ST_UPD_IR: begin
        state_d = tms_i ? ST_SEL_DR : ST_IDLE;
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
  end

  // Test clock is the only clock of the controller; test reset acts at once [RULE1] [RULE6]
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Reset for the handshake on the test clock side: asserts at once, releases on the clock
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      tck_rst_q <= 2'h0;
    end else begin
      tck_rst_q <= {tck_rst_q[0], 1'b1};
    end
  end

  assign tck_rstn = tck_rst_q[1];

  // Instruction shifter and latch; reset state reloads the identity instruction [RULE6]
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      ir_sh_q <= IR_CAPTURE;
      ir_q <= IR_RST;
    end else begin
      if (state_q == ST_CAP_IR) begin
        ir_sh_q <= IR_CAPTURE;
      end else if (state_q == ST_SHIFT_IR) begin
        ir_sh_q <= {tdi_i, ir_sh_q[IR_W-1:1]}; // [RULE3]
      end
      if (state_q == ST_RESET) begin
        ir_q <= IR_RST;
      end else if (state_q == ST_UPD_IR) begin
        ir_q <= ir_sh_q;
      end
    end
  end

  assign dr_len = len_of(ir_q);

  // Data-in enters at the top of the selected length, one bit per clock [RULE3]
  generate
    for (genvar i = 0; i < DR_MAX_W; i++) begin : g_shift
      if (i == DR_MAX_W - 1) begin : g_top
        assign dr_sh_d[i] = (dr_len == LEN_W'(i + 1)) ? tdi_i : 1'b0;
      end else begin : g_mid
        assign dr_sh_d[i] = (dr_len == LEN_W'(i + 1)) ? tdi_i : dr_sh_q[i+1];
      end
    end
  endgenerate

  // Data shifter: capture picks the source named by the instruction
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      dr_sh_q <= '0;
    end else if (state_q == ST_CAP_DR) begin
      if (ir_q == IR_IDCODE) begin
        dr_sh_q <= ID_DEFAULT;
      end else if (ir_q == IR_SAMPLE) begin
        dr_sh_q <= {{(DR_MAX_W-STAT_W){1'b0}}, stat_tck_q};
      end else if (ir_q == IR_EXTEST) begin
        dr_sh_q <= {{(DR_MAX_W-CTRL_W){1'b0}}, ctrl_tck_q};
      end else begin
        dr_sh_q <= '0;
      end
    end else if (state_q == ST_SHIFT_DR) begin
      dr_sh_q <= dr_sh_d; // [RULE3]
    end
  end

  // Output changes on the falling edge so the far end samples it cleanly [RULE4]
  always_ff @(negedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      tdo_q <= 1'b0;
      tdo_en_q <= 1'b0;
    end else begin
      tdo_q <= (state_q == ST_SHIFT_IR) ? ir_sh_q[0] : dr_sh_q[0];
      tdo_en_q <= (state_q == ST_SHIFT_IR) || (state_q == ST_SHIFT_DR); // [RULE5]
    end
  end

  // Released output enable leaves the pin floating outside shifts [RULE5]
  assign tdo_o = tdo_q;
  assign tdo_oe_n_o = ~tdo_en_q;

  // Control word applied on update; held pending if the crossing is still busy
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      ctrl_tck_q <= CTRL_RST;
      ctrl_pend_q <= 1'b0;
    end else begin
      if ((state_q == ST_UPD_DR) && (ir_q == IR_EXTEST)) begin
        ctrl_tck_q <= dr_sh_q[CTRL_W-1:0];
        ctrl_pend_q <= 1'b1;
      end else if (ctrl_pend_q && ctrl_ready) begin
        ctrl_pend_q <= 1'b0;
      end
    end
  end

  // Latest system status seen on the test clock side
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      stat_tck_q <= STAT_RST;
    end else if (stat_valid) begin
      stat_tck_q <= stat_data;
    end
  end

  // Test mode flag; cleared while the controller rests in reset [RULE8]
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      extest_q <= 1'b0;
    end else begin
      extest_q <= (ir_q == IR_EXTEST) && (state_q != ST_RESET);
    end
  end

  // Status words cross continuously; a stopped test clock simply stalls them
  word_cross #(
    .W(STAT_W)
  ) u_stat_cross (
    .src_clk_i(clk_i),
    .src_rstn_i(rstn_i),
    .src_valid_i(1'b1),
    .src_ready_o(stat_ready),
    .src_data_i(sys_status_i),
    .dst_clk_i(tck_i),
    .dst_rstn_i(tck_rstn),
    .dst_valid_o(stat_valid),
    .dst_data_o(stat_data)
  );

  word_cross #(
    .W(CTRL_W)
  ) u_ctrl_cross (
    .src_clk_i(tck_i),
    .src_rstn_i(tck_rstn),
    .src_valid_i(ctrl_pend_q),
    .src_ready_o(ctrl_ready),
    .src_data_i(ctrl_tck_q),
    .dst_clk_i(clk_i),
    .dst_rstn_i(rstn_i),
    .dst_valid_o(ctrl_valid),
    .dst_data_o(ctrl_data)
  );

  // System side: control word register and its one-cycle strobe
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl_q <= CTRL_RST;
      ctrl_vld_q <= 1'b0;
    end else begin
      ctrl_vld_q <= ctrl_valid;
      if (ctrl_valid) begin
        ctrl_q <= ctrl_data;
      end
    end
  end

  // Test mode level reaches the system clock through two flops
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mode_sync_q <= 2'h0;
    end else begin
      mode_sync_q <= {mode_sync_q[0], extest_q};
    end
  end

  assign test_ctrl_o = ctrl_q;
  assign test_ctrl_valid_o = ctrl_vld_q;
  assign test_mode_o = mode_sync_q[1];

endmodule

/* File: tb/tap_port_sva.sv */
// Checker for the test access port, watching its ports only.
// Assumes tck idles low between scans and trst changes only while tck is low.
`timescale 1ns/10ps
module tap_port_sva (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic tck_i,
  input wire logic trst_n_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_n_o,
  input wire logic [tap_pkg::STAT_W-1:0] sys_status_i,
  input wire logic [tap_pkg::CTRL_W-1:0] test_ctrl_o,
  input wire logic test_ctrl_valid_o,
  input wire logic test_mode_o
);
  import tap_pkg::*;
  logic tdo_hi_q;
  // Value seen at the rise must survive the whole high phase
  always_ff @(posedge tck_i) tdo_hi_q <= tdo_o;
  sequence s_tlr;
    tms_i [*5];
  endsequence
  sequence s_dr;
    !tms_i ##1 tms_i ##1 (!tms_i) [*2];
  endsequence
  sequence s_ir;
    !tms_i ##1 tms_i [*2] ##1 (!tms_i) [*2];
  endsequence
  property p_trst_hiz;
    @(posedge clk_i) disable iff (!rstn_i) !trst_n_i |-> tdo_oe_n_o && !tdo_o;
  endproperty
  a_trst_hiz: assert property (p_trst_hiz) else $error("tdo driven in test reset");
  property p_trst_mode;
    @(posedge clk_i) disable iff (!rstn_i) (!trst_n_i) [*4] |-> !test_mode_o;
  endproperty
  a_trst_mode: assert property (p_trst_mode) else $error("test mode kept in test reset");
  property p_tdo_fall;
    @(negedge tck_i) disable iff (!trst_n_i) tdo_o == tdo_hi_q;
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved while tck high");
  property p_tlr_hiz;
    @(posedge tck_i) disable iff (!trst_n_i) s_tlr |=> tdo_oe_n_o;
  endproperty
  a_tlr_hiz: assert property (p_tlr_hiz) else $error("tdo driven after five ones");
  property p_dr_id;
    @(posedge tck_i) disable iff (!trst_n_i) s_tlr ##1 s_dr |=> !tdo_oe_n_o && tdo_o == ID_DEFAULT[0];
  endproperty
  a_dr_id: assert property (p_dr_id) else $error("bad first id bit");
  property p_ir_cap;
    @(posedge tck_i) disable iff (!trst_n_i) s_tlr ##1 s_ir |=> !tdo_oe_n_o && tdo_o == IR_CAPTURE[0];
  endproperty
  a_ir_cap: assert property (p_ir_cap) else $error("bad first capture bit");
  property p_valid_pulse;
    @(posedge clk_i) disable iff (!rstn_i) test_ctrl_valid_o |=> !test_ctrl_valid_o;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid longer than one clock");
  property p_ctrl_valid;
    @(posedge clk_i) disable iff (!rstn_i) !$stable(test_ctrl_o) |-> test_ctrl_valid_o;
  endproperty
  a_ctrl_valid: assert property (p_ctrl_valid) else $error("control word moved without valid");
endmodule

/* File: tb/scan_ctl.sv */
// Model of the outside scan controller: drives the test pins, reads tdo.
// Assumes one task call at a time; tck stands low between frames.
`timescale 1ns/10ps
module scan_ctl (
  output logic tck_o,
  output logic trst_n_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_n_i
);
  logic last_q = 1'b0;
  // A released line shows no stale value
  wire line = tdo_oe_n_i ? ~last_q : tdo_i;
  initial begin
    tck_o = 1'b0;
    trst_n_o = 1'b0; // Power-up pulse of the test reset
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  always @(posedge tck_o) if (!tdo_oe_n_i) last_q <= tdo_i;
  // Only clock of the scan logic; pins move after the fall, tdo read at the rise
  task automatic tick(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #6;
    q = line;
    tck_o = 1'b1;
    #6;
    tck_o = 1'b0;
  endtask
  task automatic set_trst(input logic v);
    trst_n_o = v; // Held low in functional use
  endtask
  task automatic idle(input int n);
    logic q;
    repeat (n) tick(1'b0, 1'b1, q);
  endtask
  // Idle-level mode select walks back to reset
  task automatic goto_tlr();
    logic q;
    repeat (5) tick(1'b1, 1'b1, q);
  endtask
  // One bit per tck in the shift state, LSB first, ends in Idle
  task automatic scan(input bit ir, input bit from_tlr, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    if (from_tlr) begin
      goto_tlr();
      tick(1'b0, 1'b1, q);
    end
    tick(1'b1, 1'b1, q);
    if (ir) tick(1'b1, 1'b1, q);
    tick(1'b0, 1'b1, q);
    tick(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tick(1'b1, 1'b1, q);
    tick(1'b0, 1'b1, q);
  endtask
endmodule

/* File: tb/testbench.sv */
// Bench for the test access port against the scan controller model.
// Assumes clk at 50 ns, tck at 12 ns inside frames only.
`timescale 1ns/10ps
module testbench;
  import tap_pkg::*;
  logic clk_i;
  logic rstn_i;
  logic [STAT_W-1:0] sts;
  wire tck, trst_n, tms, tdi, tdo, oe_n, vld, mode;
  wire [CTRL_W-1:0] ctrl;
  int err_count = 0;
  int n_checks = 0;
  logic [31:0] d;
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  scan_ctl ctl (.tck_o(tck), .trst_n_o(trst_n), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_n_i(oe_n));
  tap_port i_tap_port (.clk_i(clk_i), .rstn_i(rstn_i), .tck_i(tck), .trst_n_i(trst_n), .tms_i(tms),
    .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_n_o(oe_n), .sys_status_i(sts), .test_ctrl_o(ctrl),
    .test_ctrl_valid_o(vld), .test_mode_o(mode));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (err_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic wait_vld();
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_i);
      #2;
      if (vld === 1'b1) break;
    end
    if (i == 40) begin
      err_count++;
      stop_test();
    end
  endtask
  task automatic t_reset();
    check("oe_n", 32'(oe_n), 32'h1);
    check("mode", 32'(mode), 32'h0);
    check("ctrl", 32'(ctrl), 32'(CTRL_RST));
  endtask
  task automatic t_ir_bypass();
    ctl.scan(1'b1, 1'b1, 4, 32'(IR_BYPASS), d);
    check("ir capture", d, 32'(IR_CAPTURE));
    ctl.scan(1'b0, 1'b0, 8, 32'ha5, d);
    check("bypass", d, 32'h4a);
    check("oe_n idle", 32'(oe_n), 32'h1);
  endtask
  task automatic t_idcode();
    ctl.scan(1'b0, 1'b1, 32, 32'h0, d);
    check("idcode", d, ID_DEFAULT);
  endtask
  task automatic t_extest();
    ctl.scan(1'b1, 1'b0, 4, 32'(IR_EXTEST), d);
    // Test mode flag is a test clock register, so it needs one more edge
    ctl.idle(1);
    clks(6);
    check("mode on", 32'(mode), 32'h1);
    ctl.scan(1'b0, 1'b0, 16, 32'h5a3c, d);
    check("ctrl reset capture", d, 32'(CTRL_RST));
    // Pending word enters the crossing only on a later test clock edge
    ctl.idle(2);
    wait_vld();
    check("ctrl word", 32'(ctrl), 32'h5a3c);
    ctl.scan(1'b0, 1'b0, 16, 32'h0, d);
    check("ctrl capture", d, 32'h5a3c);
    ctl.idle(2);
    wait_vld();
    check("ctrl zero", 32'(ctrl), 32'h0);
  endtask
  task automatic t_sample();
    sts = 16'hc3e1;
    clks(10);
    ctl.scan(1'b1, 1'b0, 4, 32'(IR_SAMPLE), d);
    // Status crosses only while tck runs
    ctl.idle(20);
    ctl.scan(1'b0, 1'b0, 16, 32'h0, d);
    check("status", d, 32'hc3e1);
    sts = 16'h1e5a;
    clks(10);
    // A stale word may be in flight first, so allow two round trips
    ctl.idle(30);
    ctl.scan(1'b0, 1'b0, 16, 32'h0, d);
    check("status again", d, 32'h1e5a);
  endtask
  task automatic t_trst();
    logic q;
    ctl.scan(1'b1, 1'b0, 4, 32'(IR_EXTEST), d);
    ctl.tick(1'b1, 1'b1, q);
    ctl.tick(1'b0, 1'b1, q);
    ctl.tick(1'b0, 1'b1, q);
    ctl.tick(1'b0, 1'b1, q);
    check("oe_n shift", 32'(oe_n), 32'h0);
    ctl.set_trst(1'b0);
    #1;
    check("oe_n trst", 32'(oe_n), 32'h1);
    clks(6);
    check("mode trst", 32'(mode), 32'h0);
    ctl.set_trst(1'b1);
    ctl.idle(2);
    ctl.scan(1'b0, 1'b0, 32, 32'h0, d);
    check("id after trst", d, ID_DEFAULT);
  endtask
  initial begin
    rstn_i = 1'b0;
    sts = '0;
    clks(4);
    ctl.set_trst(1'b1);
    // Three test clocks end clear of the next system edge
    ctl.idle(3);
    clks(8);
    rstn_i = 1'b1;
    clks(2);
    t_reset();
    t_ir_bypass();
    t_idcode();
    t_extest();
    t_sample();
    t_trst();
    stop_test();
  end
endmodule
bind tap_port tap_port_sva u_sva (.clk_i(clk_i), .rstn_i(rstn_i), .tck_i(tck_i), .trst_n_i(trst_n_i),
  .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o), .sys_status_i(sys_status_i),
  .test_ctrl_o(test_ctrl_o), .test_ctrl_valid_o(test_ctrl_valid_o), .test_mode_o(test_mode_o));
